// File: logic/regulator_voltage_code_regs.sv
// register bank holding output voltage codes for regulators four to six
module regulator_voltage_code_regs
    import vcode_regs_pkg::*;
(
    input  wire logic              CLK,
    input  wire logic              RST,
    input  wire logic              WR_EN,
    input  wire logic              RD_EN,
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic [DATA_W-1:0] WDATA,
    input  wire logic [DATA_W-1:0] FACTORY_REG4_SLEEP,
    input  wire logic [DATA_W-1:0] FACTORY_REG5_NORMAL,
    input  wire logic [DATA_W-1:0] FACTORY_REG5_SLEEP,
    input  wire logic [DATA_W-1:0] FACTORY_REG6_NORMAL,
    input  wire logic              FACTORY_LOAD,
    input  wire logic              SLEEP_PIN_ONE,
    input  wire logic              SLEEP_PIN_TWO,
    output logic [DATA_W-1:0]      RDATA,
    output logic [CODE_W-1:0]      REG4_TARGET_CODE,
    output logic [CODE_W-1:0]      REG5_TARGET_CODE,
    output logic [CODE_W-1:0]      REG6_TARGET_CODE,
    output logic                   REG5_PASSIVE_DECAY,
    output logic                   REG6_PASSIVE_DECAY
);
    // regulator 4 normal code and regulators' sleep pin assignment sit outside
    parameter code_t       REG4_NORMAL_CODE = 7'h00;
    parameter logic        REG4_SLEEP_ON_TWO = 1'b0;
    parameter logic        REG5_SLEEP_ON_TWO = 1'b0;
    parameter step_range_t STEP_RANGE       = STEP_10MV;

    // -------------------------------------------------------------------------
    // storage
    // -------------------------------------------------------------------------
    code_t reg4_sleep_code_ff;
    code_t reg5_normal_code_ff;
    code_t reg5_sleep_code_ff;
    code_t reg6_normal_code_ff;
    logic  reg5_decay_select_ff;
    logic  reg6_decay_select_ff;
    logic  loaded_ff;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    // any of the four mapped offsets; checks of refused accesses lean on it
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = hit(a, OFS_REG4_SLEEP) || hit(a, OFS_REG5_NORMAL) ||
                 hit(a, OFS_REG5_SLEEP) || hit(a, OFS_REG6_NORMAL);
    endfunction

    // async reset clears; factory image loaded once after release,
    // since a flop may not take a port value under async reset
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            loaded_ff <= 1'b0;
        end else if (FACTORY_LOAD) begin
            loaded_ff <= 1'b1;
        end
    end

    // register writes; reserved bit 0 of sleep registers never stored
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            reg4_sleep_code_ff   <= '0;
            reg5_normal_code_ff  <= '0;
            reg5_sleep_code_ff   <= '0;
            reg6_normal_code_ff  <= '0;
            reg5_decay_select_ff <= 1'b0;
            reg6_decay_select_ff <= 1'b0;
        end else if (FACTORY_LOAD && !loaded_ff) begin
            reg4_sleep_code_ff   <= FACTORY_REG4_SLEEP[CODE_MSB:CODE_LSB];
            reg5_normal_code_ff  <= FACTORY_REG5_NORMAL[CODE_MSB:CODE_LSB];
            reg5_decay_select_ff <= FACTORY_REG5_NORMAL[DECAY_BIT];
            reg5_sleep_code_ff   <= FACTORY_REG5_SLEEP[CODE_MSB:CODE_LSB];
            reg6_normal_code_ff  <= FACTORY_REG6_NORMAL[CODE_MSB:CODE_LSB];
            reg6_decay_select_ff <= FACTORY_REG6_NORMAL[DECAY_BIT];
        end else if (WR_EN) begin
            if (hit(ADDR, OFS_REG4_SLEEP)) begin
                reg4_sleep_code_ff <= WDATA[CODE_MSB:CODE_LSB];
            end
            if (hit(ADDR, OFS_REG5_NORMAL)) begin
                reg5_normal_code_ff  <= WDATA[CODE_MSB:CODE_LSB];
                reg5_decay_select_ff <= WDATA[DECAY_BIT];
            end
            if (hit(ADDR, OFS_REG5_SLEEP)) begin
                reg5_sleep_code_ff <= WDATA[CODE_MSB:CODE_LSB];
            end
            if (hit(ADDR, OFS_REG6_NORMAL)) begin
                reg6_normal_code_ff  <= WDATA[CODE_MSB:CODE_LSB];
                reg6_decay_select_ff <= WDATA[DECAY_BIT];
            end
        end
    end

    // -------------------------------------------------------------------------
    // read path, registered; reserved bit reads zero
    // -------------------------------------------------------------------------
    logic [DATA_W-1:0] nxt_rdata;
    always_comb begin
        nxt_rdata = UNMAPPED_VAL;
        if (hit(ADDR, OFS_REG4_SLEEP)) begin
            nxt_rdata = {reg4_sleep_code_ff, RESERVED_VAL};
        end else if (hit(ADDR, OFS_REG5_NORMAL)) begin
            nxt_rdata = {reg5_normal_code_ff, reg5_decay_select_ff};
        end else if (hit(ADDR, OFS_REG5_SLEEP)) begin
            nxt_rdata = {reg5_sleep_code_ff, RESERVED_VAL};
        end else if (hit(ADDR, OFS_REG6_NORMAL)) begin
            nxt_rdata = {reg6_normal_code_ff, reg6_decay_select_ff};
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            RDATA <= '0;
        end else if (RD_EN) begin
            RDATA <= nxt_rdata;
        end
    end

    // -------------------------------------------------------------------------
    // target code selection; low sleep pin picks sleep code
    // -------------------------------------------------------------------------
    logic reg4_asleep;
    logic reg5_asleep;
    assign reg4_asleep = REG4_SLEEP_ON_TWO ? !SLEEP_PIN_TWO : !SLEEP_PIN_ONE;
    assign reg5_asleep = REG5_SLEEP_ON_TWO ? !SLEEP_PIN_TWO : !SLEEP_PIN_ONE;

    // codes pass untouched; the analog side reads them per STEP_RANGE
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            REG4_TARGET_CODE   <= '0;
            REG5_TARGET_CODE   <= '0;
            REG6_TARGET_CODE   <= '0;
            REG5_PASSIVE_DECAY <= 1'b0;
            REG6_PASSIVE_DECAY <= 1'b0;
        end else begin
            REG4_TARGET_CODE   <= reg4_asleep ? reg4_sleep_code_ff : REG4_NORMAL_CODE;
            REG5_TARGET_CODE   <= reg5_asleep ? reg5_sleep_code_ff : reg5_normal_code_ff;
            REG6_TARGET_CODE   <= reg6_normal_code_ff;
            REG5_PASSIVE_DECAY <= reg5_decay_select_ff;
            REG6_PASSIVE_DECAY <= reg6_decay_select_ff;
        end
    end

    // -------------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------------
    a_reg5_normal_write: assert property (@(posedge CLK) disable iff (RST)
        (WR_EN && ADDR == OFS_REG5_NORMAL && !(FACTORY_LOAD && !loaded_ff))
        |=> reg5_normal_code_ff == $past(WDATA[CODE_MSB:CODE_LSB]))
        else $error("reg5 normal code not stored");
    a_reg6_normal_write: assert property (@(posedge CLK) disable iff (RST)
        (WR_EN && ADDR == OFS_REG6_NORMAL && !(FACTORY_LOAD && !loaded_ff))
        |=> reg6_normal_code_ff == $past(WDATA[CODE_MSB:CODE_LSB]))
        else $error("reg6 normal code not stored");
    a_reg4_sleep_write: assert property (@(posedge CLK) disable iff (RST)
        (WR_EN && ADDR == OFS_REG4_SLEEP && !(FACTORY_LOAD && !loaded_ff))
        |=> reg4_sleep_code_ff == $past(WDATA[CODE_MSB:CODE_LSB]))
        else $error("reg4 sleep code not stored");
    a_reg5_sleep_write: assert property (@(posedge CLK) disable iff (RST)
        (WR_EN && ADDR == OFS_REG5_SLEEP && !(FACTORY_LOAD && !loaded_ff))
        |=> reg5_sleep_code_ff == $past(WDATA[CODE_MSB:CODE_LSB]))
        else $error("reg5 sleep code not stored");
    a_reserved_reads_zero: assert property (@(posedge CLK) disable iff (RST)
        (RD_EN && (ADDR == OFS_REG4_SLEEP || ADDR == OFS_REG5_SLEEP))
        |=> RDATA[DECAY_BIT] == RESERVED_VAL)
        else $error("reserved bit read nonzero");
    a_decay_follows: assert property (@(posedge CLK) disable iff (RST)
        (WR_EN && ADDR == OFS_REG5_NORMAL && !(FACTORY_LOAD && !loaded_ff))
        |=> ##1 REG5_PASSIVE_DECAY == $past(WDATA[DECAY_BIT], 2))
        else $error("reg5 decay select not applied");
    a_sleep_select: assert property (@(posedge CLK) disable iff (RST)
        (!REG5_SLEEP_ON_TWO && !SLEEP_PIN_ONE)
        |=> REG5_TARGET_CODE == $past(reg5_sleep_code_ff))
        else $error("reg5 sleep code not selected");
    a_awake_select: assert property (@(posedge CLK) disable iff (RST)
        (!REG5_SLEEP_ON_TWO && SLEEP_PIN_ONE)
        |=> REG5_TARGET_CODE == $past(reg5_normal_code_ff))
        else $error("reg5 normal code not selected");
    a_factory_load: assert property (@(posedge CLK) disable iff (RST)
        (FACTORY_LOAD && !loaded_ff)
        |=> reg6_normal_code_ff == $past(FACTORY_REG6_NORMAL[CODE_MSB:CODE_LSB]))
        else $error("factory image not loaded");

    // factory image ordering: load wins over a write, and happens once
    a_load_beats_write: assert property (@(posedge CLK) disable iff (RST)
        (FACTORY_LOAD && !loaded_ff && WR_EN && ADDR == OFS_REG6_NORMAL)
        |=> reg6_normal_code_ff == $past(FACTORY_REG6_NORMAL[CODE_MSB:CODE_LSB]))
        else $error("write overrode factory image");
    a_load_only_once: assert property (@(posedge CLK) disable iff (RST)
        (loaded_ff && !WR_EN)
        |=> $stable(reg5_normal_code_ff))
        else $error("factory image reloaded");

    // regulator 4 and 6 outputs
    a_reg4_sleep_target: assert property (@(posedge CLK) disable iff (RST)
        (!REG4_SLEEP_ON_TWO && !SLEEP_PIN_ONE)
        |=> REG4_TARGET_CODE == $past(reg4_sleep_code_ff))
        else $error("reg4 sleep code not selected");
    a_reg4_awake_target: assert property (@(posedge CLK) disable iff (RST)
        (!REG4_SLEEP_ON_TWO && SLEEP_PIN_ONE)
        |=> REG4_TARGET_CODE == REG4_NORMAL_CODE)
        else $error("reg4 normal code not selected");
    a_reg6_target_follows: assert property (@(posedge CLK) disable iff (RST)
        (WR_EN && ADDR == OFS_REG6_NORMAL && !(FACTORY_LOAD && !loaded_ff))
        |=> ##1 REG6_TARGET_CODE == $past(WDATA[CODE_MSB:CODE_LSB], 2))
        else $error("reg6 target not applied");
    a_reg6_decay_follows: assert property (@(posedge CLK) disable iff (RST)
        (WR_EN && ADDR == OFS_REG6_NORMAL && !(FACTORY_LOAD && !loaded_ff))
        |=> ##1 REG6_PASSIVE_DECAY == $past(WDATA[DECAY_BIT], 2))
        else $error("reg6 decay select not applied");

    // read path and refused accesses
    a_unmapped_reads_zero: assert property (@(posedge CLK) disable iff (RST)
        (RD_EN && !mapped(ADDR))
        |=> RDATA == UNMAPPED_VAL)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (@(posedge CLK) disable iff (RST)
        (!RD_EN)
        |=> $stable(RDATA))
        else $error("read data moved without a read");
    a_unmapped_write_ignored: assert property (@(posedge CLK) disable iff (RST)
        (WR_EN && !mapped(ADDR) && !(FACTORY_LOAD && !loaded_ff))
        |=> $stable(reg4_sleep_code_ff) && $stable(reg5_normal_code_ff)
            && $stable(reg5_sleep_code_ff) && $stable(reg6_normal_code_ff))
        else $error("unmapped write changed a code");
endmodule

// File: logic/vcode_regs_pkg.sv
// constants and types shared by the regulator voltage code register bank
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
package vcode_regs_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam int          CODE_W          = 7;
    localparam logic [7:0]  OFS_REG4_SLEEP  = 8'h95;
    localparam logic [7:0]  OFS_REG5_NORMAL = 8'h96;
    localparam logic [7:0]  OFS_REG5_SLEEP  = 8'h97;
    localparam logic [7:0]  OFS_REG6_NORMAL = 8'h98;
    localparam int          CODE_MSB        = 7;
    localparam int          CODE_LSB        = 1;
    localparam int          DECAY_BIT       = 0;
    localparam logic        RESERVED_VAL    = 1'b0;
    localparam logic [7:0]  UNMAPPED_VAL    = 8'h00;
    // step range of the code, fixed per factory option
    typedef enum logic {STEP_10MV = 1'b0, STEP_25MV = 1'b1} step_range_t;
    typedef logic [CODE_W-1:0] code_t;
endpackage

// File: verif/regulator_voltage_code_regs_bench.sv
// self-checking bench for the regulator voltage code register bank
module regulator_voltage_code_regs_bench
    import vcode_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] r;} row_t;
    logic clk = 1'b0, rst = 1'b1, fload = 1'b0, wr_en, rd_en, s1_n, s2_n, d5, d6;
    logic [7:0] addr, wdata, rdata, rd;
    logic [6:0] t4, t5, t6;
    int failures = 0, total_checks = 0;
    row_t rows[5] = '{'{8'h95, 8'hff, 8'hfe}, '{8'h96, 8'h0b, 8'h0b},
        '{8'h97, 8'h03, 8'h02}, '{8'h98, 8'h81, 8'h81}, '{8'h90, 8'hff, 8'h00}};
    always #12.5 clk = ~clk;
    vcode_host host (.clk(clk), .rdata(rdata), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wdata(wdata), .sleep_one_n(s1_n), .sleep_two_n(s2_n));
    regulator_voltage_code_regs DUT (.CLK(clk), .RST(rst), .WR_EN(wr_en), .RD_EN(rd_en),
        .ADDR(addr), .WDATA(wdata), .FACTORY_REG4_SLEEP(8'h54), .FACTORY_REG5_NORMAL(8'h71),
        .FACTORY_REG5_SLEEP(8'h38), .FACTORY_REG6_NORMAL(8'hbe), .FACTORY_LOAD(fload),
        .SLEEP_PIN_ONE(s1_n), .SLEEP_PIN_TWO(s2_n), .RDATA(rdata), .REG4_TARGET_CODE(t4),
        .REG5_TARGET_CODE(t5), .REG6_TARGET_CODE(t6), .REG5_PASSIVE_DECAY(d5),
        .REG6_PASSIVE_DECAY(d6));
    // single comparison point, counts every compare
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // watchdog: a hang counts as a mismatch
    initial begin
        #100us;
        failures++;
        conclude();
    end
    initial begin
        repeat (4) @(posedge clk);
        check(rdata, 8'h00, "rdata in reset");
        check({1'b0, t5}, 8'h00, "target in reset");
        rst <= 1'b0;
        // a write landing in the load cycle must lose to the factory image
        fork
            host.write_reg(8'h98, 8'h00);
        join_none
        @(posedge clk);
        fload <= 1'b1;
        repeat (2) @(posedge clk);
        fload <= 1'b0;
        host.read_reg(8'h95, rd);
        check(rd, 8'h54, "factory sleep4");
        host.read_reg(8'h98, rd);
        check(rd, 8'hbe, "factory normal6");
        // ordinary cases: write then read back, reserved bit and unmapped place included
        foreach (rows[i]) begin
            host.write_reg(rows[i].a, rows[i].d);
            host.read_reg(rows[i].a, rd);
            check(rd, rows[i].r, "readback");
        end
        repeat (2) @(posedge clk);
        #1;
        check({1'b0, t4}, 8'h00, "normal target4");
        check({1'b0, t5}, 8'h05, "normal target5");
        check({1'b0, t6}, 8'h40, "normal target6");
        check({7'h00, d5}, 8'h01, "decay5 passive");
        check({7'h00, d6}, 8'h01, "decay6 passive");
        // sleep pin one low selects the sleep codes, pin two alone does not
        host.set_sleep(1'b0, 1'b1);
        repeat (2) @(posedge clk);
        #1;
        check({1'b0, t4}, 8'h7f, "sleep target4");
        check({1'b0, t5}, 8'h01, "sleep target5");
        host.set_sleep(1'b1, 1'b0);
        repeat (2) @(posedge clk);
        #1;
        check({1'b0, t5}, 8'h05, "pin two ignored");
        // two successive writes, each clears its own regulator's decay select
        host.write_reg(8'h96, 8'h0c);
        host.write_reg(8'h98, 8'h80);
        repeat (2) @(posedge clk);
        #1;
        check({7'h00, d5}, 8'h00, "decay5 active");
        check({7'h00, d6}, 8'h00, "decay6 active");
        check({1'b0, t6}, 8'h40, "target6 kept");
        check({1'b0, t5}, 8'h06, "target5 rewritten");
        // second reset mid-run without a factory load
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        host.read_reg(8'h96, rd);
        check(rd, 8'h00, "cleared by reset");
        conclude();
    end
endmodule

// File: verif/vcode_host.sv
// host-side stand-in driving the register strobes and the sleep pins
module vcode_host
    import vcode_regs_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [DATA_W-1:0] rdata,
    output logic                   wr_en,
    output logic                   rd_en,
    output logic [ADDR_W-1:0]      addr,
    output logic [DATA_W-1:0]      wdata,
    output logic                   sleep_one_n,
    output logic                   sleep_two_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus, no sleep request
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        sleep_one_n = 1'b1;
        sleep_two_n = 1'b1;
    end
    // one-cycle write strobe; data inverted afterwards so stale bytes are never reused
    task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        wdata <= ~d;
    endtask
    // read data is registered, so take it once the answering edge has landed
    task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask
    // sleep pins are active low levels
    task automatic set_sleep(input logic one_n, input logic two_n);
        @(posedge clk);
        sleep_one_n <= one_n;
        sleep_two_n <= two_n;
    endtask
endmodule
